// >>> bridge_transaction_sequencer.sv
/*
 * instrument end of the bridge serial link: address match, strobe detection,
 * response shifting, configuration state, conversion alarm and result load.
 * assumes the host drives clock pulse and data line asynchronously to clk_sys_i,
 * slow enough (400 ns period) for edge detection at 20 MHz.
 */
`default_nettype none
module bridge_transaction_sequencer
   import bridge_seq_pkg::*;
#(
   parameter logic [bridge_seq_pkg::CNT_W-1:0] CONV_CYC = bridge_seq_pkg::CONV_CYC_DEF,
   parameter logic [bridge_seq_pkg::CNT_W-1:0] LOAD_CYC = bridge_seq_pkg::LOAD_CYC_DEF
) (
   input  wire  logic                       clk_sys_i,
   input  wire  logic                       reset_i,
   input  wire  bridge_seq_pkg::apb_req_s   apb_i,
   output logic [31:0]                      prdata_o,
   output logic                             pready_o,
   output logic                             pslverr_o,
   input  wire  logic                       bus_clock_pulse_i,
   input  wire  logic                       host_data_line_i,
   output logic                             instr_data_o,
   output logic                             conversion_alarm_o
);
   import bridge_seq_pkg::*;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // ==========================================================
   // pin synchronisers
   // each stage owns its flops, so every bit has one driver
   wire  [1:0] sync2;
   logic [1:0] pins;
   assign pins = {bus_clock_pulse_i, host_data_line_i};
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sync
         logic meta;
         logic stable;
         always_ff @(posedge clk_sys_i or posedge reset_i) begin
            if (reset_i) begin
               meta   <= 1'b0;
               stable <= 1'b0;
            end else begin
               meta   <= pins[g];
               stable <= meta;
            end
         end
         assign sync2[g] = stable;
      end
   endgenerate

   logic cp_d;
   logic dc_d;
   wire  cp_s   = sync2[1];
   wire  dc_s   = sync2[0];
   wire  cp_ris = cp_s & ~cp_d;
   wire  dc_tog = (dc_s ^ dc_d) & ~cp_s;

   // ==========================================================
   // link framing state
   phase_e           phase;
   logic [5:0]       bit_cnt;
   logic [2:0]       tog_cnt;
   logic [7:0]       addr_sh;
   logic [CFG_W-1:0] rx_sh;
   logic [CFG_W-1:0] tx_sh;
   logic [CFG_W-1:0] cfg;
   logic             selected;
   logic [7:0]       dev_addr;
   reading_s         adc_in;
   reading_s         conv_latch;
   reading_s         result_out;

   wire strobe   = dc_tog & (tog_cnt == STROBE_EDGES - 3'h1);
   wire addr_end = strobe & (phase == PH_ADDR) & (bit_cnt == ADDR_BITS);
   wire data_end = strobe & (phase == PH_DATA);
   wire addr_ok  = (addr_sh == dev_addr);
   wire take_cfg = data_end & selected & (bit_cnt == DATA_BITS);
   // previous state goes out while the new string comes in
   wire [CFG_W-1:0] response = {cfg[CFG_W-BCD_W-2:0], result_out};

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         cp_d    <= 1'b0;
         dc_d    <= 1'b0;
         tog_cnt <= '0;
      end else begin
         cp_d    <= cp_s;
         dc_d    <= dc_s;
         if (cp_ris || strobe) begin
            tog_cnt <= '0;
         end else if (dc_tog) begin
            tog_cnt <= tog_cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         phase    <= PH_ADDR;
         bit_cnt  <= '0;
         addr_sh  <= '0;
         rx_sh    <= '0;
         tx_sh    <= '0;
         selected <= 1'b0;
      end else if (addr_end) begin
         phase    <= PH_DATA;
         bit_cnt  <= '0;
         selected <= addr_ok;
         tx_sh    <= response;
      end else if (strobe) begin
         // any other strobe realigns to a fresh address phase
         phase    <= PH_ADDR;
         bit_cnt  <= '0;
         selected <= 1'b0;
      end else if (cp_ris) begin
         if (bit_cnt != 6'h3F) begin
            bit_cnt <= bit_cnt + 6'h01;
         end
         if (phase == PH_ADDR) begin
            addr_sh <= {addr_sh[6:0], dc_s};
         end else if (selected) begin
            rx_sh <= {rx_sh[CFG_W-2:0], dc_s};
            tx_sh <= {tx_sh[CFG_W-2:0], 1'b0};
         end
      end
   end

   // configuration takes effect only at the closing strobe
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         cfg <= '0;
         cfg[ALARM_DIS_BIT] <= 1'b1;
      end else if (take_cfg) begin
         cfg <= rx_sh;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         instr_data_o <= 1'b0;
      end else begin
         instr_data_o <= selected & (phase == PH_DATA) & tx_sh[CFG_W-1];
      end
   end

   // ==========================================================
   // conversion timing and result load
   conv_e            cstate;
   logic [CNT_W-1:0] ccnt;
   wire alarm_en  = ~cfg[ALARM_DIS_BIT];
   wire conv_done = (cstate == CV_RUN) & (ccnt == CONV_CYC - 1'b1);
   wire load_done = (cstate == CV_LOAD) & (ccnt == LOAD_CYC - 1'b1);
   // overload forces a zero value so a stale number cannot pass as valid
   wire reading_s conv_val = adc_in.overload_flag ? reading_s'{overload_flag: 1'b1, bcd: '0} : adc_in;

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         cstate     <= CV_IDLE;
         ccnt       <= '0;
         conv_latch <= '0;
         result_out <= '0;
      end else begin
         case (cstate)
            CV_IDLE: begin
               ccnt <= '0;
               if (alarm_en) begin
                  cstate <= CV_RUN;
               end
            end
            CV_RUN: begin
               if (!alarm_en) begin
                  cstate <= CV_IDLE;
               end else if (conv_done) begin
                  conv_latch <= conv_val;
                  ccnt       <= '0;
                  cstate     <= CV_LOAD;
               end else begin
                  ccnt <= ccnt + 1'b1;
               end
            end
            CV_LOAD: begin
               if (load_done) begin
                  result_out <= conv_latch;
                  ccnt       <= '0;
                  cstate     <= alarm_en ? CV_RUN : CV_IDLE;
               end else begin
                  ccnt <= ccnt + 1'b1;
               end
            end
            default: begin
               cstate <= CV_IDLE;
               ccnt   <= '0;
            end
         endcase
      end
   end

   // set wins over the clear taken at the next selected address strobe
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         conversion_alarm_o <= 1'b0;
      end else if (conv_done) begin
         conversion_alarm_o <= 1'b1;
      end else if (!alarm_en || (addr_end && addr_ok)) begin
         conversion_alarm_o <= 1'b0;
      end
   end

   // ==========================================================
   // apb slave, zero wait states
   wire       setup   = apb_i.psel & ~apb_i.penable;
   wire       wr_acc  = apb_i.psel & apb_i.penable & pready_o & apb_i.pwrite;
   wire [7:0] a       = apb_i.paddr;
   wire       mapped  = hit(a, OFS_CTRL) | hit(a, OFS_ADC) | hit(a, OFS_STATUS)
                        | hit(a, OFS_CFG_LO) | hit(a, OFS_CFG_HI);
   wire [31:0] rd_mux =
      hit(a, OFS_CTRL)   ? {24'h000000, dev_addr} :
      hit(a, OFS_ADC)    ? {adc_in.overload_flag, 14'h0000, adc_in.bcd} :
      hit(a, OFS_STATUS) ? {24'h000000, 1'b0, cstate, phase, selected, conversion_alarm_o} :
      hit(a, OFS_CFG_LO) ? cfg[31:0] :
      hit(a, OFS_CFG_HI) ? {16'h0000, cfg[CFG_W-1:32]} : 32'h00000000;

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= '0;
      end else begin
         pready_o  <= setup;
         pslverr_o <= setup & ~mapped;
         prdata_o  <= (setup & ~apb_i.pwrite) ? rd_mux : 32'h00000000;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         dev_addr <= DEV_ADDR_RST;
         adc_in   <= '0;
      end else if (wr_acc && hit(a, OFS_CTRL)) begin
         dev_addr <= apb_i.pwdata[7:0];
      end else if (wr_acc && hit(a, OFS_ADC)) begin
         adc_in <= '{overload_flag: apb_i.pwdata[ADC_OVR_BIT], bcd: apb_i.pwdata[BCD_W-1:0]};
      end
   end

   // ==========================================================
   // checks
   // age of the running conversion; later periodic alarms must not trip the deadline
   logic [CNT_W-1:0] en_age;
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         en_age <= '0;
      end else if (!alarm_en || cstate != CV_RUN) begin
         en_age <= '0;
      end else if (en_age != '1) begin
         en_age <= en_age + 1'b1;
      end
   end

   alarm_deadline_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $rose(conversion_alarm_o) |-> $past(alarm_en) && en_age <= CONV_CYC + 1'b1)
      else $error("alarm later than conversion period after enable");

   response_prev_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      addr_end && addr_ok |=> tx_sh == $past(response) && phase == PH_DATA)
      else $error("response not loaded from previous state");

   result_load_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      load_done |=> result_out == $past(conv_latch) && cstate != CV_LOAD)
      else $error("result not moved to output after load wait");

   overload_zero_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      result_out.overload_flag |-> result_out.bcd == '0)
      else $error("overload reading not zero");
endmodule
`default_nettype wire

// >>> bridge_seq_pkg.sv
/*
 * shared constants and carriers of the bridge transaction sequencer (instrument end).
 * assumes a 20 MHz system clock and an APB master with 32-bit data.
 */
`default_nettype none
package bridge_seq_pkg;
   // ==========================================================
   // clock and timing
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned CONV_TIME_MS  = 400;
   localparam int unsigned LOAD_TIME_MS  = 5;
   localparam int unsigned CNT_W         = 23;
   localparam logic [CNT_W-1:0] CONV_CYC_DEF = CNT_W'(CONV_TIME_MS * (CLK_HZ / 1000));
   localparam logic [CNT_W-1:0] LOAD_CYC_DEF = CNT_W'(LOAD_TIME_MS * (CLK_HZ / 1000));

   // ==========================================================
   // link framing
   localparam logic [5:0] ADDR_BITS    = 6'h08;
   localparam logic [5:0] DATA_BITS    = 6'h30;
   localparam logic [2:0] STROBE_EDGES = 3'h5;
   localparam int unsigned CFG_W       = 48;
   localparam int unsigned BCD_W       = 17;
   localparam int unsigned ALARM_DIS_BIT = 0;
   localparam int unsigned REMOTE_BIT    = 1;
   localparam logic [7:0] DEV_ADDR_RST = 8'h01;

   // ==========================================================
   // register map
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_ADC     = 8'h04;
   localparam logic [7:0] OFS_STATUS  = 8'h08;
   localparam logic [7:0] OFS_CFG_LO  = 8'h0C;
   localparam logic [7:0] OFS_CFG_HI  = 8'h10;
   localparam int unsigned ADC_OVR_BIT = 31;

   typedef enum logic [1:0] {PH_ADDR = 2'b01, PH_DATA = 2'b10} phase_e;
   typedef enum logic [2:0] {CV_IDLE = 3'b001, CV_RUN = 3'b010, CV_LOAD = 3'b100} conv_e;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic             overload_flag;
      logic [BCD_W-1:0] bcd;
   } reading_s;
endpackage
`default_nettype wire

// >>> bridge_host_model.sv
/*
 * host end model of the bridge serial link: clock pulse, data line, strobes.
 * assumes the bench system clock; one link bit takes 8 clocks (400 ns).
 */
`default_nettype none
module bridge_host_model
   import bridge_seq_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        instr_data_i,
   output logic             cp_o,
   output logic             dc_o,
   output logic             done_o,
   output logic [47:0]      resp_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cp_o = 1'b0;
      dc_o = 1'b0;
      done_o = 1'b0;
      resp_o = '0;
   end

   // ==========================================================
   // bit and strobe
   // clock stays low between frames, never free running
   task automatic send_bit(input logic b, output logic s);
      @(posedge clk_i) dc_o <= b;
      repeat (4) @(posedge clk_i);
      s = instr_data_i;
      cp_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      cp_o <= 1'b0;
   endtask

   task automatic strobe();
      repeat (6) begin
         @(posedge clk_i) dc_o <= ~dc_o;
         repeat (3) @(posedge clk_i);
      end
   endtask

   // ==========================================================
   // one transaction
   task automatic transact(input logic [7:0] addr, input logic [47:0] cfg);
      logic        s;
      logic [47:0] r;
      for (int i = 7; i >= 0; i--) send_bit(addr[i], s);
      strobe();
      for (int i = 47; i >= 0; i--) begin
         send_bit(cfg[i], s);
         r[i] = s;
      end
      strobe();
      @(posedge clk_i) begin
         resp_o <= r;
         done_o <= 1'b1;
      end
      @(posedge clk_i) done_o <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// >>> bridge_transaction_sequencer_tb.sv
/*
 * self-checking bench of the instrument end: apb master, host link model.
 * assumes shortened conversion and load counts; notes checked in order.
 */
`default_nettype none
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin n_mismatch++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (w)); end end
module bridge_transaction_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import bridge_seq_pkg::*;
   localparam logic [CNT_W-1:0] CONV = 23'h7D0;
   localparam logic [CNT_W-1:0] LOAD = 23'h0C8;
   logic        clk_sys_i = 1'b0;
   logic        reset_i = 1'b1;
   apb_req_s    apb = '0;
   logic [31:0] prdata_o;
   logic        pready_o, pslverr_o, instr_data_o, conversion_alarm_o;
   logic        cp, dc, done;
   logic [47:0] resp, exp_v, cur, cfg_s;
   logic [47:0] exp_q[$];
   logic [17:0] res;
   logic [31:0] seed = 32'hA849;
   int          n_mismatch = 0;
   int          checks_done = 0;

   always #25 clk_sys_i = ~clk_sys_i;

   bridge_transaction_sequencer #(.CONV_CYC(CONV), .LOAD_CYC(LOAD)) dut_u (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .apb_i(apb), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .bus_clock_pulse_i(cp),
      .host_data_line_i(dc), .instr_data_o(instr_data_o),
      .conversion_alarm_o(conversion_alarm_o));

   bridge_host_model host_u (.clk_i(clk_sys_i), .instr_data_i(instr_data_o), .cp_o(cp),
      .dc_o(dc), .done_o(done), .resp_o(resp));

   // ==========================================================
   // tasks
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // request held until pready is sampled high at a rising edge; only the watchdog ends a wait
   task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i) apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk_sys_i) apb.penable <= 1'b1;
      do begin
         @(posedge clk_sys_i);
      end while (!pready_o);
      apb <= '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back({15'h0, e});
      apb_xfer(1'b0, a, 32'h0);
   endtask

   task automatic link(input logic [7:0] a, input logic [47:0] c, input logic [47:0] e);
      exp_q.push_back(e);
      host_u.transact(a, c);
   endtask

   task automatic report_and_stop();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // result watcher
   always @(posedge clk_sys_i) begin
      if (apb.psel && apb.penable && pready_o && !apb.pwrite) begin
         exp_v = exp_q.pop_front();
         `CHK({15'h0, pslverr_o, prdata_o}, exp_v)
      end
      if (done) begin
         exp_v = exp_q.pop_front();
         `CHK(resp, exp_v)
      end
   end

   // ==========================================================
   // sequence
   initial begin
      repeat (6) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      rd(OFS_CTRL, {1'b0, 32'h1});
      rd(OFS_STATUS, {1'b0, 24'h0, 1'b0, CV_IDLE, PH_ADDR, 2'b00});
      rd(8'h14, {1'b1, 32'h0});
      apb_xfer(1'b1, OFS_CFG_LO, 32'hFFFFFFFF);
      rd(OFS_CFG_LO, {1'b0, 32'h1});
      seed = lfsr_next(seed);
      cur = {seed[15:0], seed[31:1], 1'b1};
      cur[REMOTE_BIT] = 1'b0;
      link(8'h01, cur, 48'h000000040000);
      link(8'h01, cur, {cur[29:0], 18'h0});
      rd(OFS_CFG_LO, {1'b0, cur[31:0]});
      rd(OFS_CFG_HI, {17'h0, cur[47:32]});
      // foreign address: silent line, configuration kept
      link(8'h02, ~cur, 48'h0);
      rd(OFS_CFG_LO, {1'b0, cur[31:0]});
      res = '0;
      for (int k = 0; k < 2; k++) begin
         seed = lfsr_next(seed);
         apb_xfer(1'b1, OFS_ADC, {k[0], 14'h0, seed[16:0]});
         rd(OFS_ADC, {1'b0, k[0], 14'h0, seed[16:0]});
         cfg_s = cur;
         cfg_s[ALARM_DIS_BIT] = 1'b0;
         cfg_s[REMOTE_BIT] = 1'b1;
         link(8'h01, cfg_s, {cur[29:0], res});
         cur = cfg_s;
         link(8'h01, cfg_s, {cur[29:0], res});
         // poll count starts afresh for each wait; running out is the timeout
         for (int n = 0; n < 2100; n++) begin
            if (!conversion_alarm_o) @(negedge clk_sys_i);
         end
         `CHK(conversion_alarm_o, 1'b1)
         rd(OFS_STATUS, {1'b0, 24'h0, 1'b0, CV_LOAD, PH_ADDR, 2'b01});
         repeat (2 * LOAD) @(posedge clk_sys_i);
         res = k[0] ? {1'b1, 17'h0} : {1'b0, seed[16:0]};
         link(8'h01, cfg_s, {cur[29:0], res});
         cur = cfg_s;
         cur[ALARM_DIS_BIT] = 1'b1;
         link(8'h01, cur, {cfg_s[29:0], res});
         repeat (20) @(negedge clk_sys_i);
         `CHK(conversion_alarm_o, 1'b0)
      end
      report_and_stop();
   end

   // hang guard, well above the expected run length
   initial begin
      repeat (40000) @(posedge clk_sys_i);
      n_mismatch++;
      report_and_stop();
   end
endmodule
`default_nettype wire
